/* File: common/lsso_pkg.sv */
// Shared constants and types for the long skip/sub/swap executor
`default_nettype none

package lsso_pkg;

    // ------------------------------------------------------------
    // Data widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;          // Byte width of memory and accumulator
    localparam int NIB_W = 4;           // Nibble width
    localparam int STAT_W = 6;          // Number of status bits kept here

    // ------------------------------------------------------------
    // Status bit positions inside status_out
    // ------------------------------------------------------------
    localparam int STAT_SIGNED_EXCESS_POS = 0;  // Signed overflow
    localparam int STAT_ZERO_POS = 1;           // Result zero
    localparam int STAT_HALF_BORROW_POS = 2;    // Low nibble borrow state
    localparam int STAT_CARRY_POS = 3;          // Carry, low on borrow
    localparam int STAT_SIGNED_BORROW_POS = 4;  // Signed less-than
    localparam int STAT_CHAINED_NULL_POS = 5;   // Chained zero

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RST = 8'h00;      // Accumulator after reset
    localparam logic [5:0] STATUS_RST = 6'h00;   // Status bits after reset
    localparam logic [7:0] ZERO_BYTE = 8'h00;    // Value that a skip tests against

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam logic [1:0] LONG_OP_CYCLES = 2'h2;   // Cycles of any op here, not counting the dummy slot of a taken skip
    localparam logic [1:0] EXEC_CNT_RST = 2'h0;     // Idle counter value
    localparam logic [1:0] EXEC_CNT_LOAD = 2'(LONG_OP_CYCLES - 2'h1); // Busy cycles

    // ------------------------------------------------------------
    // Operations of the group
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        skip_if_nonzero_long,
        skip_if_zero_long,
        load_and_skip_if_zero,
        subtract_into_accumulator,
        subtract_into_memory,
        nibble_exchange_in_place,
        nibble_exchange_to_accumulator
    } lsso_op_e;

endpackage

`default_nettype wire

/* File: hw/lsso_alu.sv */
// Combinational subtractor and nibble exchanger for the long op executor
`timescale 1ns/100ps
`default_nettype none

module lsso_alu
    import lsso_pkg::*;
(
    input wire logic [7:0] acc_in,          // Current accumulator
    input wire logic [7:0] mem_in,          // Addressed memory byte
    output logic [7:0] diff_out,            // Accumulator minus memory
    output logic [5:0] sub_flags_out,       // Status bits for a subtract
    output logic [7:0] swap_out             // Memory byte, nibbles exchanged
);

    // ------------------------------------------------------------
    // Nibble exchange
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NIB_W; gi++) begin : g_swap
            // Low nibble goes high and high nibble goes low
            assign swap_out[gi + NIB_W] = mem_in[gi];
            assign swap_out[gi] = mem_in[gi + NIB_W];
        end
    endgenerate

    // ------------------------------------------------------------
    // Subtractor and its flags
    // ------------------------------------------------------------
    logic [8:0] wide_diff;   // Bit 8 set on full borrow
    logic [4:0] nib_diff;    // Bit 4 set on low nibble borrow
    logic ovf;               // Signed overflow

    // One extra bit on each subtract exposes the borrow without a compare
    always_comb begin
        wide_diff = {1'b0, acc_in} - {1'b0, mem_in};
        nib_diff = {1'b0, acc_in[3:0]} - {1'b0, mem_in[3:0]};
        diff_out = wide_diff[7:0];
        // Operands of unlike sign whose result sign follows the subtrahend
        ovf = (acc_in[7] ^ mem_in[7]) & (acc_in[7] ^ wide_diff[7]);
        sub_flags_out = STATUS_RST;
        sub_flags_out[STAT_SIGNED_EXCESS_POS] = ovf;
        sub_flags_out[STAT_ZERO_POS] = (wide_diff[7:0] == ZERO_BYTE);
        sub_flags_out[STAT_HALF_BORROW_POS] = ~nib_diff[4];
        sub_flags_out[STAT_CARRY_POS] = ~wide_diff[8];
        sub_flags_out[STAT_SIGNED_BORROW_POS] = ovf ^ wide_diff[7];
        // No carry chain in this subtract, so chained zero is plain zero
        sub_flags_out[STAT_CHAINED_NULL_POS] = (wide_diff[7:0] == ZERO_BYTE);
    end

endmodule

`default_nettype wire

/* File: hw/lsso_exec.sv */
// Executor for the long skip, subtract and nibble exchange operations
`timescale 1ns/100ps
`default_nettype none

module lsso_exec
    import lsso_pkg::*;
(
    input wire logic ref_clk_in,                 // System clock, 100 MHz
    input wire logic reset_in,                   // Synchronous reset, high
    input wire logic op_valid_in,                // Operation request
    input wire lsso_op_e op_code_in,             // Which operation
    input wire logic [7:0] mem_data_in,          // Addressed memory byte
    input wire logic acc_load_in,                // Load accumulator from core
    input wire logic [7:0] acc_load_data_in,     // Value for that load
    output logic op_ready_out,                   // Request may be taken
    output logic [7:0] acc_out,                  // Accumulator
    output logic [5:0] status_out,               // Status bits
    output logic mem_wr_en_out,                  // Memory write strobe
    output logic [7:0] mem_wr_data_out,          // Memory write data
    output logic skip_taken_out,                 // Next op is suppressed
    output logic dummy_cycle_out,                // Inserted dummy cycle
    output logic op_done_out                     // Operation finished
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // True for the three conditional skip operations
    // Only these may ask for a dummy slot
    function automatic logic is_skip_op(input lsso_op_e op);
        return (op == skip_if_nonzero_long) ||
               (op == skip_if_zero_long) ||
               (op == load_and_skip_if_zero);
    endfunction

    // True for the two subtract operations
    // Only these two may rewrite the status bits
    function automatic logic is_sub_op(input lsso_op_e op);
        return (op == subtract_into_accumulator) ||
               (op == subtract_into_memory);
    endfunction

    // True where the skip condition for the op holds on this byte
    function automatic logic skip_cond(input lsso_op_e op, input logic [7:0] b);
        logic zero;
        zero = (b == ZERO_BYTE);
        case (op)
            skip_if_nonzero_long: skip_cond = !zero;
            skip_if_zero_long: skip_cond = zero;
            load_and_skip_if_zero: skip_cond = zero;
            // Codes outside the skip group never skip
            default: skip_cond = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Arithmetic datapath
    // ------------------------------------------------------------
    logic [7:0] diff;        // Accumulator minus memory
    logic [5:0] sub_flags;   // Flags that a subtract would produce
    logic [7:0] swapped;     // Memory byte with nibbles exchanged

    // Declared early: the subtractor reads the accumulator
    logic [7:0] acc_ff;           // Accumulator
    logic [7:0] nxt_acc;
    logic [5:0] status_ff;        // Status bits
    logic [5:0] nxt_status;
    logic wr_en_ff;               // Memory write strobe
    logic nxt_wr_en;
    logic [7:0] wr_data_ff;       // Memory write data
    logic [7:0] nxt_wr_data;

    // Subtract and exchange are both always ready; the decode picks one
    // The accumulator operand comes from a flop, so a core load cannot race it
    lsso_alu u_alu (
        .acc_in(acc_ff),
        .mem_in(mem_data_in),
        .diff_out(diff),
        .sub_flags_out(sub_flags),
        .swap_out(swapped)
    );

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    // Body phase, then the dummy slot of a taken skip
    typedef enum logic [1:0] {
        lsso_idle,       // Waiting for an operation
        lsso_exec_st,    // Remaining body cycles of an operation
        lsso_dummy       // Dummy cycle in place of the skipped op
    } lsso_state_e;

    lsso_state_e state_ff;        // Current sequencer state
    lsso_state_e nxt_state;       // Next sequencer state
    logic [1:0] cnt_ff;           // Body cycles left
    logic [1:0] nxt_cnt;

    logic skip_ff;                // Pending skip for this op
    logic nxt_skip;
    logic ready_ff;               // Registered ready
    logic nxt_ready;

    // Pulses below are high for one cycle each
    logic done_ff;                // Registered completion pulse
    logic nxt_done;
    logic dummy_ff;               // Registered dummy marker
    logic nxt_dummy;
    logic skip_out_ff;            // Registered skip marker
    logic nxt_skip_out;

    // Request taken only while idle and ready
    // Busy requests fall away with no sign
    logic take;
    assign take = op_valid_in && ready_ff;

    // Work out where the sequence goes next
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_skip = skip_ff;
        nxt_ready = ready_ff;
        nxt_done = 1'b0;
        nxt_dummy = 1'b0;
        nxt_skip_out = 1'b0;

        // Pulses stay low unless a phase ends
        case (state_ff)
            lsso_idle: begin
                // Sit here until a request is taken
                if (take) begin
                    // First cycle is the request cycle itself
                    nxt_state = lsso_exec_st;
                    nxt_cnt = EXEC_CNT_LOAD;
                    nxt_skip = is_skip_op(op_code_in) &&
                               skip_cond(op_code_in, mem_data_in);
                    nxt_ready = 1'b0;
                end
            end
            lsso_exec_st: begin
                if (cnt_ff > 2'h1) begin
                    // Longer bodies just count down
                    nxt_cnt = cnt_ff - 2'h1;
                end else if (skip_ff) begin
                    // Fetch of the next op goes on under a dummy slot
                    nxt_state = lsso_dummy;
                    nxt_cnt = EXEC_CNT_RST;
                    nxt_dummy = 1'b1;
                    nxt_skip_out = 1'b1;
                end else begin
                    // No dummy cycle when the skip is not taken
                    nxt_state = lsso_idle;
                    nxt_cnt = EXEC_CNT_RST;
                    // Ready returns with done: back to back ops
                    nxt_ready = 1'b1;
                    nxt_done = 1'b1;
                end
            end
            lsso_dummy: begin
                // Third cycle over; the skipped op never executes
                // Next fetch already ran under this slot
                nxt_state = lsso_idle;
                nxt_skip = 1'b0;
                nxt_ready = 1'b1;
                nxt_done = 1'b1;
            end
            default: begin
                // Unreachable encoding, recover to idle
                // No pulse is raised on the way out
                nxt_state = lsso_idle;
                nxt_cnt = EXEC_CNT_RST;
                nxt_skip = 1'b0;
                nxt_ready = 1'b1;
            end
        endcase
    end

    // Register the sequencer
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            // Ready at once, so an op may follow release
            state_ff <= lsso_idle;
            cnt_ff <= EXEC_CNT_RST;
            skip_ff <= 1'b0;
            ready_ff <= 1'b1;
            done_ff <= 1'b0;
            dummy_ff <= 1'b0;
            skip_out_ff <= 1'b0;
        end else begin
            // Straight copy of the next values
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            skip_ff <= nxt_skip;
            ready_ff <= nxt_ready;
            done_ff <= nxt_done;
            dummy_ff <= nxt_dummy;
            skip_out_ff <= nxt_skip_out;
        end
    end

    // ------------------------------------------------------------
    // Architectural state: accumulator, status, memory write
    // ------------------------------------------------------------

    // Results are committed in the request cycle so the core sees them
    // one edge later, whether or not a dummy cycle follows
    always_comb begin
        nxt_acc = acc_ff;
        nxt_status = status_ff;
        nxt_wr_en = 1'b0;
        nxt_wr_data = wr_data_ff;

        // A taken request wins over a core load
        if (take) begin
            case (op_code_in)
                subtract_into_accumulator: begin
                    // Memory is not written
                    nxt_acc = diff;
                end
                subtract_into_memory: begin
                    // Accumulator left as it was
                    nxt_wr_en = 1'b1;
                    nxt_wr_data = diff;
                end
                load_and_skip_if_zero: begin
                    // Copy happens whatever the skip outcome
                    nxt_acc = mem_data_in;
                end
                nibble_exchange_in_place: begin
                    // Accumulator is kept
                    nxt_wr_en = 1'b1;
                    nxt_wr_data = swapped;
                end
                nibble_exchange_to_accumulator: begin
                    // Memory byte is not rewritten
                    nxt_acc = swapped;
                end
                default: begin
                    // Plain skips change no data
                    nxt_acc = acc_ff;
                end
            endcase

            // Only subtracts touch the flags
            if (is_sub_op(op_code_in)) begin
                nxt_status = sub_flags;
            end
        end else if (acc_load_in && ready_ff) begin
            // Load from other core logic only between operations
            // A load while busy is dropped with no sign
            nxt_acc = acc_load_data_in;
        end
    end

    // Register the architectural state
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            // No subtract has run, so status starts clear
            acc_ff <= ACC_RST;
            status_ff <= STATUS_RST;
            wr_en_ff <= 1'b0;
            wr_data_ff <= ZERO_BYTE;
        end else begin
            // Registers only copy; all choice is above
            acc_ff <= nxt_acc;
            status_ff <= nxt_status;
            wr_en_ff <= nxt_wr_en;
            wr_data_ff <= nxt_wr_data;
        end
    end

    // ------------------------------------------------------------
    // Outputs, each straight from a flip-flop
    // ------------------------------------------------------------
    // No output is decoded from state, so none can glitch
    assign op_ready_out = ready_ff;
    assign acc_out = acc_ff;
    assign status_out = status_ff;
    assign mem_wr_en_out = wr_en_ff;
    assign mem_wr_data_out = wr_data_ff;
    // One-cycle markers of the op sequence
    assign skip_taken_out = skip_out_ff;
    assign dummy_cycle_out = dummy_ff;
    assign op_done_out = done_ff;

endmodule

`default_nettype wire

/* File: test/lsso_exec_props.sv */
// Concurrent checks on the ports of the long skip, subtract and swap executor
`timescale 1ns/100ps
`default_nettype none

module lsso_exec_props
    import lsso_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic op_valid_in,
    input wire lsso_op_e op_code_in,
    input wire logic [7:0] mem_data_in,
    input wire logic acc_load_in,
    input wire logic [7:0] acc_load_data_in,
    input wire logic op_ready_out,
    input wire logic [7:0] acc_out,
    input wire logic [5:0] status_out,
    input wire logic mem_wr_en_out,
    input wire logic [7:0] mem_wr_data_out,
    input wire logic skip_taken_out,
    input wire logic dummy_cycle_out,
    input wire logic op_done_out
);
    // ------------------------------------------------------------
    // Helper decode of the request cycle
    // ------------------------------------------------------------
    logic take;         // Request accepted at this edge
    logic is_sub;       // Either subtract
    logic is_skip;      // Any op that may skip
    logic skip_hit;     // Skip condition met
    logic no_borrow;    // Whole-byte compare for carry
    logic nib_ok;       // Low nibble compare for half borrow
    logic [7:0] diff;   // Expected difference
    logic [7:0] swapped; // Memory byte with nibbles exchanged
    assign take = op_valid_in && op_ready_out;
    assign is_sub = op_code_in inside {subtract_into_accumulator, subtract_into_memory};
    assign is_skip = op_code_in inside {skip_if_nonzero_long, skip_if_zero_long,
                                        load_and_skip_if_zero};
    assign skip_hit = (op_code_in == skip_if_nonzero_long) ? (mem_data_in != ZERO_BYTE)
                                                           : (mem_data_in == ZERO_BYTE);
    assign no_borrow = acc_out >= mem_data_in;
    assign nib_ok = acc_out[3:0] >= mem_data_in[3:0];
    assign diff = acc_out - mem_data_in;
    assign swapped = {mem_data_in[3:0], mem_data_in[7:4]};

    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    // ------------------------------------------------------------
    // Skip timing
    // ------------------------------------------------------------
    property p_skip_taken;
        take && is_skip && skip_hit
            |=> !op_ready_out ##1 (skip_taken_out && dummy_cycle_out) ##1 op_done_out;
    endproperty
    a_skip_taken: assert property (p_skip_taken) else $error("skip timing wrong");
    property p_no_skip;
        take && is_skip && !skip_hit |=> ##1 (op_done_out && !dummy_cycle_out && !skip_taken_out);
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("untaken skip wrong");

    // ------------------------------------------------------------
    // Data results
    // ------------------------------------------------------------
    property p_load_skip;
        take && op_code_in == load_and_skip_if_zero |=> acc_out == $past(mem_data_in);
    endproperty
    a_load_skip: assert property (p_load_skip) else $error("load and skip acc wrong");
    property p_sub_acc;
        take && op_code_in == subtract_into_accumulator
            |=> acc_out == $past(diff) && !mem_wr_en_out;
    endproperty
    a_sub_acc: assert property (p_sub_acc) else $error("subtract to acc wrong");
    property p_sub_mem;
        take && op_code_in == subtract_into_memory
            |=> mem_wr_en_out && mem_wr_data_out == $past(diff) && $stable(acc_out);
    endproperty
    a_sub_mem: assert property (p_sub_mem) else $error("subtract to memory wrong");
    property p_carry;
        take && is_sub |=> status_out[STAT_CARRY_POS] == $past(no_borrow);
    endproperty
    a_carry: assert property (p_carry) else $error("carry after subtract wrong");
    property p_half;
        take && is_sub |=> status_out[STAT_HALF_BORROW_POS] == $past(nib_ok);
    endproperty
    a_half: assert property (p_half) else $error("half borrow wrong");
    // Status must hold for the two cycles after the request, not just the first
    property p_flags_kept;
        take && !is_sub |=> $stable(status_out) [*2];
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("status changed");
    property p_swap_mem;
        take && op_code_in == nibble_exchange_in_place
            |=> mem_wr_en_out && mem_wr_data_out == $past(swapped);
    endproperty
    a_swap_mem: assert property (p_swap_mem) else $error("in-place swap wrong");
    property p_swap_acc;
        take && op_code_in == nibble_exchange_to_accumulator
            |=> acc_out == $past(swapped) && !mem_wr_en_out;
    endproperty
    a_swap_acc: assert property (p_swap_acc) else $error("swap to acc wrong");
endmodule

`default_nettype wire

/* File: test/lsso_exec_tb.sv */
// Self-checking bench for the long skip, subtract and swap executor
`timescale 1ns/100ps
`default_nettype none

module lsso_exec_tb
    import lsso_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus, results and bookkeeping
    // ------------------------------------------------------------
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic op_valid_in = 1'b0;
    lsso_op_e op_code_in = skip_if_nonzero_long;
    logic [7:0] mem_data_in = 8'h00;
    logic acc_load_in = 1'b0;
    logic [7:0] acc_load_data_in = 8'h00;
    logic op_ready_out, mem_wr_en_out, skip_taken_out, dummy_cycle_out, op_done_out;
    logic [7:0] acc_out, mem_wr_data_out;
    logic [5:0] status_out;
    logic [7:0] acc_c1, wrd_c1;  // Values 1 ns after the take edge
    logic [5:0] st_c1, st_pre;   // Status then, and before the request
    logic wr_c1, skip_seen, dummy_seen;
    int fails = 0;
    int check_count = 0;
    int cycles;
    int tick = 0;

    always #5 ref_clk_in = ~ref_clk_in;

    lsso_exec lsso_exec_inst (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .op_valid_in(op_valid_in),
        .op_code_in(op_code_in), .mem_data_in(mem_data_in), .acc_load_in(acc_load_in),
        .acc_load_data_in(acc_load_data_in), .op_ready_out(op_ready_out), .acc_out(acc_out),
        .status_out(status_out), .mem_wr_en_out(mem_wr_en_out),
        .mem_wr_data_out(mem_wr_data_out), .skip_taken_out(skip_taken_out),
        .dummy_cycle_out(dummy_cycle_out), .op_done_out(op_done_out)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Accumulator load only lands while idle, so call between ops
    task automatic set_acc(input logic [7:0] v);
        @(posedge ref_clk_in);
        acc_load_in <= 1'b1;
        acc_load_data_in <= v;
        @(posedge ref_clk_in);
        acc_load_in <= 1'b0;
    endtask

    // One op from request to done; bounded wait so a lost done cannot hang
    task automatic run_op(input lsso_op_e op, input logic [7:0] m);
        @(posedge ref_clk_in);
        op_valid_in <= 1'b1;
        op_code_in <= op;
        mem_data_in <= m;
        #1 st_pre = status_out;
        @(posedge ref_clk_in);
        op_valid_in <= 1'b0;
        #1 {acc_c1, st_c1, wr_c1, wrd_c1} = {acc_out, status_out, mem_wr_en_out, mem_wr_data_out};
        {cycles, skip_seen, dummy_seen} = {32'd1, 2'b00};
        while (op_done_out !== 1'b1 && cycles < 6) begin
            @(posedge ref_clk_in);
            #1 cycles++;
            skip_seen |= (skip_taken_out === 1'b1);
            dummy_seen |= (dummy_cycle_out === 1'b1);
        end
    endtask

    // Expected six status bits of a subtract
    function automatic logic [5:0] sub_flags(input logic [7:0] a, input logic [7:0] m);
        logic [7:0] d;
        logic [5:0] f;
        d = a - m;
        f[STAT_CARRY_POS] = a >= m;
        f[STAT_ZERO_POS] = d == 8'h00;
        f[STAT_HALF_BORROW_POS] = a[3:0] >= m[3:0];
        f[STAT_SIGNED_EXCESS_POS] = (a[7] != m[7]) && (d[7] != a[7]);
        f[STAT_SIGNED_BORROW_POS] = f[STAT_SIGNED_EXCESS_POS] ^ d[7];
        f[STAT_CHAINED_NULL_POS] = f[STAT_ZERO_POS];
        return f;
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        @(posedge ref_clk_in);
        #1 chk("acc", ACC_RST, acc_out);
        chk("status", 8'(STATUS_RST), 8'(status_out));
        chk("ready", 8'h01, 8'(op_ready_out));
        $display("test_reset done");
    endtask

    // Borrow, no borrow, signed overflow both ways, equal, nibble borrow
    task automatic test_sub();
        logic [7:0] av[6] = '{8'h05, 8'h07, 8'h80, 8'h7F, 8'h33, 8'h10};
        logic [7:0] mv[6] = '{8'h07, 8'h05, 8'h01, 8'hFF, 8'h33, 8'h01};
        for (int i = 0; i < 6; i++) begin
            set_acc(av[i]);
            run_op(subtract_into_accumulator, mv[i]);
            chk("sub acc", av[i] - mv[i], acc_c1);
            chk("sub flags", 8'(sub_flags(av[i], mv[i])), 8'(st_c1));
            chk("sub cycles", 8'h02, 8'(cycles));
            set_acc(av[i]);
            run_op(subtract_into_memory, mv[i]);
            chk("subm write", {7'h00, 1'b1}, 8'(wr_c1));
            chk("subm data", av[i] - mv[i], wrd_c1);
            chk("subm acc", av[i], acc_c1);
            chk("subm flags", 8'(sub_flags(av[i], mv[i])), 8'(st_c1));
        end
        $display("test_sub done");
    endtask

    // Status holds the last subtract's nonzero flags throughout
    task automatic test_skips();
        lsso_op_e ov[5] = '{skip_if_nonzero_long, skip_if_nonzero_long, skip_if_nonzero_long,
                            skip_if_zero_long, skip_if_zero_long};
        logic [7:0] mv[5] = '{8'h00, 8'h01, 8'h80, 8'h00, 8'hFF};
        logic hit;
        for (int i = 0; i < 5; i++) begin
            run_op(ov[i], mv[i]);
            hit = (ov[i] == skip_if_nonzero_long) ? (mv[i] != 8'h00) : (mv[i] == 8'h00);
            chk("skip", 8'(hit), 8'(skip_seen));
            chk("dummy", 8'(hit), 8'(dummy_seen));
            chk("cycles", hit ? 8'h03 : 8'h02, 8'(cycles));
            chk("skip status", 8'(st_pre), 8'(st_c1));
        end
        $display("test_skips done");
    endtask

    task automatic test_load_and_skip_if_zero();
        set_acc(8'h5A);
        run_op(load_and_skip_if_zero, 8'h00);
        chk("load_and_skip_if_zero acc", 8'h00, acc_c1);
        chk("load_and_skip_if_zero skip", 8'h01, 8'(skip_seen));
        chk("load_and_skip_if_zero cycles", 8'h03, 8'(cycles));
        run_op(load_and_skip_if_zero, 8'h3C);
        chk("load_and_skip_if_zero acc", 8'h3C, acc_c1);
        chk("load_and_skip_if_zero noskip", 8'h00, 8'(skip_seen));
        $display("test_load_and_skip_if_zero done");
    endtask

    task automatic test_swap();
        set_acc(8'h11);
        run_op(nibble_exchange_in_place, 8'hA5);
        chk("swap write", 8'h01, 8'(wr_c1));
        chk("swap data", 8'h5A, wrd_c1);
        chk("swap acc", 8'h11, acc_c1);
        chk("swap status", 8'(st_pre), 8'(st_c1));
        run_op(nibble_exchange_to_accumulator, 8'h3C);
        chk("swapa acc", 8'hC3, acc_c1);
        chk("swapa write", 8'h00, 8'(wr_c1));
        chk("swapa status", 8'(st_pre), 8'(st_c1));
        $display("test_swap done");
    endtask

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk_in) begin
        tick <= tick + 1;
        if (tick == 3000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (12) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        test_reset();
        test_sub();
        test_skips();
        test_load_and_skip_if_zero();
        test_swap();
        tally_and_finish();
    end
endmodule

bind lsso_exec lsso_exec_props lsso_exec_props_inst (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .op_valid_in(op_valid_in),
    .op_code_in(op_code_in), .mem_data_in(mem_data_in), .acc_load_in(acc_load_in),
    .acc_load_data_in(acc_load_data_in), .op_ready_out(op_ready_out), .acc_out(acc_out),
    .status_out(status_out), .mem_wr_en_out(mem_wr_en_out), .mem_wr_data_out(mem_wr_data_out),
    .skip_taken_out(skip_taken_out), .dummy_cycle_out(dummy_cycle_out),
    .op_done_out(op_done_out)
);

`default_nettype wire
